// ---- design/sts_pkg.sv ----
// Purpose: Constants and types shared by the self-test supervisor
// Assumes: One clock at 100 MHz, asynchronous active-high reset
// Notes:   Widths are fixed; no software-visible registers
package sts_pkg;
	localparam int        REC_W        = 64;
	localparam int        CRC_W        = 16;
	localparam logic [15:0] CRC_POLY   = 16'h1021;
	localparam logic [15:0] CRC_INIT   = 16'hFFFF;
	localparam int        BLK_W        = 32;
	localparam logic [5:0] ONES_MIN    = 6'h0A;
	localparam logic [5:0] ONES_MAX    = 6'h16;
	localparam logic [5:0] PW_MIN      = 6'h0F;
	localparam logic [5:0] PW_MAX      = 6'h1E;
	localparam logic [7:0] ASCII_LO    = 8'h20;
	localparam logic [7:0] ASCII_HI    = 8'h7E;
	localparam int        IND_NS       = 1000;
	localparam int        CLK_NS       = 10;
	localparam int        IND_CYC      = IND_NS / CLK_NS;
	localparam logic [7:0] IND_CYC_W   = 8'(IND_CYC);
	localparam int        IND_N        = 2;
	localparam logic [1:0] IND_ALL     = 2'h3;

	typedef enum logic [10:0] {
		STS_IND_ON   = 11'h001,
		STS_IND_OFF  = 11'h002,
		STS_SIG      = 11'h004,
		STS_ENC      = 11'h008,
		STS_DEC      = 11'h010,
		STS_GEN1     = 11'h020,
		STS_GEN2     = 11'h040,
		STS_REF      = 11'h080,
		STS_READY    = 11'h100,
		STS_ERR_HARD = 11'h200,
		STS_LOAD_ONLY = 11'h400
	} sts_state_t;
endpackage

// ---- design/sts_sync.sv ----
// Purpose: Two-flip-flop synchroniser for one level from outside the clock domain
// Assumes: Input is a level held for several cycles
// Notes:   First stage feeds only the second
module sts_sync (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic d,
	output logic      q
);
	logic meta;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta <= 1'b0;
			q    <= 1'b0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ---- design/sts_supervisor.sv ----
// Purpose: Power-up and conditional self-test supervisor with service gating
// Assumes: Engines (cipher, hash, generator, signature) are outside and answer by strobes
// Notes:   Power cycle equals sys_rst; only the synchronised pins are read by logic

// What this block does
// - Each key record carries a CRC over all fields; mismatch flags corruption.
// - Zeroize command clears the held first generator block and generator output; the reference is kept.
// - Power-up and on demand, run every cipher mode and hash; compare with expected.
// - After encryption, decrypt the result and compare with the original plaintext.
// - Generator check: seed, block, reseed, block; pass only when blocks differ.
// - Generator check also counts ones; out-of-range count fails it.
// - At power-up, verify code signature; integrity passes only on success.
// - At power-up drive every indicator active, then inactive.
// - Power off to on starts the whole power-up self-test set.
// - New code image is accepted only if its signature verifies.
// - At power-up store one generator output as reference only, never released.
// - Each later output equal to reference fails; else replace reference and return.
// - Algorithm, continuous or generator check failure: error until power cycle.
// - Integrity failure: error, show indication, then allow only code loading.
// - Load failure: error until power cycle; restart download afterwards.
// - Status indicator shows all tests passed or a failure error.
// - No cryptographic operation is performed in any error state.
// - Only one authenticated operator session at a time.
// - Key loading holds off crypto, service grants and data output until it completes.
// - Password accepted only with 15 to 30 printable ASCII characters.
// - No external read path to plaintext secret or private keys.
// - Data output suppressed during self-tests and any error state.
module sts_supervisor (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	// Self-test engines
	input  wire logic                        test_req_pin,
	output logic                             eng_start,
	output sts_pkg::sts_state_t              eng_step,
	input  wire logic                        eng_done,
	input  wire logic                        eng_match,
	input  wire logic [sts_pkg::BLK_W-1:0]   eng_block,
	// Generator requests
	input  wire logic                        rng_valid,
	input  wire logic [sts_pkg::BLK_W-1:0]   rng_data,
	output logic                             rng_out_valid,
	output logic [sts_pkg::BLK_W-1:0]        rng_out,
	// Code download
	input  wire logic                        load_done,
	input  wire logic                        load_sig_ok,
	output logic                             load_accept,
	// Key records
	input  wire logic                        rec_valid,
	input  wire logic [sts_pkg::REC_W-1:0]   rec_fields,
	input  wire logic [sts_pkg::CRC_W-1:0]   rec_crc,
	output logic                             rec_corrupt,
	output logic [sts_pkg::CRC_W-1:0]        rec_crc_new,
	// Zeroize, keys, sessions
	input  wire logic                        zeroize_pin,
	output logic                             zeroize_now,
	output logic                             key_read_en,
	input  wire logic                        login_req,
	input  wire logic                        logout_req,
	input  wire logic [5:0]                  pw_len,
	input  wire logic                        pw_printable,
	output logic                             login_ok,
	output logic                             session_active,
	input  wire logic                        keyload_busy,
	// Service gating and status
	input  wire logic                        svc_req,
	output logic                             svc_grant,
	output logic                             crypto_en,
	output logic                             data_out_en,
	output logic                             ready,
	output logic                             status_pass,
	output logic                             status_error,
	output logic [sts_pkg::IND_N-1:0]        indicators
);
	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	logic test_req_s;
	logic zeroize_s;

	sts_sync u_sync_test (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (test_req_pin),
		.q       (test_req_s)
	);
	sts_sync u_sync_zero (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (zeroize_pin),
		.q       (zeroize_s)
	);

	//------------------------------------------------------------
	// State and datapath registers
	//------------------------------------------------------------
	sts_pkg::sts_state_t   state;
	sts_pkg::sts_state_t   next_state;
	logic [7:0]            ind_cnt;
	logic [sts_pkg::BLK_W-1:0] blk1;
	logic [sts_pkg::BLK_W-1:0] ref_val;
	logic                  test_req_d;
	logic                  busy;
	logic                  gen_ok;

	wire test_rise  = test_req_s & ~test_req_d;
	wire ind_tick   = (ind_cnt == sts_pkg::IND_CYC_W);
	wire in_err     = (state == sts_pkg::STS_ERR_HARD) || (state == sts_pkg::STS_LOAD_ONLY);
	wire in_ready   = (state == sts_pkg::STS_READY);
	wire testing    = ~in_err & ~in_ready;
	wire step_done  = eng_done & eng_start;

	// Ones count of the second block, checked against range
	logic [5:0] ones;
	always_comb begin
		ones = 6'h00;
		for (int i = 0; i < sts_pkg::BLK_W; i++) begin
			ones = ones + 6'(eng_block[i]);
		end
	end
	wire ones_ok  = (ones >= sts_pkg::ONES_MIN) && (ones <= sts_pkg::ONES_MAX);
	wire blk_diff = (eng_block != blk1);

	// Engine is started in every step that needs it
	assign eng_step  = state;
	assign eng_start = (state == sts_pkg::STS_SIG) || (state == sts_pkg::STS_ENC)
		|| (state == sts_pkg::STS_DEC) || (state == sts_pkg::STS_GEN1)
		|| (state == sts_pkg::STS_GEN2) || (state == sts_pkg::STS_REF);

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			sts_pkg::STS_IND_ON:  if (ind_tick) next_state = sts_pkg::STS_IND_OFF;
			sts_pkg::STS_IND_OFF: if (ind_tick) next_state = sts_pkg::STS_SIG;
			sts_pkg::STS_SIG: if (step_done) begin
				next_state = eng_match ? sts_pkg::STS_ENC : sts_pkg::STS_LOAD_ONLY;
			end
			sts_pkg::STS_ENC: if (step_done) begin
				next_state = eng_match ? sts_pkg::STS_DEC : sts_pkg::STS_ERR_HARD;
			end
			sts_pkg::STS_DEC: if (step_done) begin
				next_state = eng_match ? sts_pkg::STS_GEN1 : sts_pkg::STS_ERR_HARD;
			end
			sts_pkg::STS_GEN1: if (step_done) next_state = sts_pkg::STS_GEN2;
			sts_pkg::STS_GEN2: if (step_done) begin
				next_state = (blk_diff && ones_ok) ? sts_pkg::STS_REF
					: sts_pkg::STS_ERR_HARD;
			end
			sts_pkg::STS_REF: if (step_done) next_state = sts_pkg::STS_READY;
			sts_pkg::STS_READY: begin
				if (gen_ok == 1'b0) next_state = sts_pkg::STS_ERR_HARD;
				else if (test_rise) next_state = sts_pkg::STS_ENC;
			end
			sts_pkg::STS_LOAD_ONLY: if (load_done && !load_sig_ok) begin
				next_state = sts_pkg::STS_ERR_HARD;
			end
			sts_pkg::STS_ERR_HARD: next_state = sts_pkg::STS_ERR_HARD;
			default: next_state = sts_pkg::STS_ERR_HARD;
		endcase
	end

	// Reset is the power cycle: all tests restart from the top
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= sts_pkg::STS_IND_ON;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ind_cnt    <= 8'h00;
			test_req_d <= 1'b0;
		end else begin
			test_req_d <= test_req_s;
			ind_cnt    <= (ind_tick || next_state != state) ? 8'h00 : ind_cnt + 8'h01;
		end
	end

	//------------------------------------------------------------
	// Generator blocks and continuous comparison
	//------------------------------------------------------------
	wire rng_same = rng_valid && (rng_data == ref_val);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			blk1          <= '0;
			ref_val       <= '0;
			gen_ok        <= 1'b1;
			rng_out_valid <= 1'b0;
			rng_out       <= '0;
		end else begin
			rng_out_valid <= 1'b0;
			if (state == sts_pkg::STS_GEN1 && step_done) begin
				blk1 <= eng_block;
			end
			if (state == sts_pkg::STS_REF && step_done) begin
				ref_val <= eng_block;
			end
			if (in_ready && rng_valid && !zeroize_s) begin
				if (rng_same) begin
					gen_ok <= 1'b0;
				end else begin
					ref_val       <= rng_data;
					rng_out       <= rng_data;
					rng_out_valid <= 1'b1;
				end
			end
			if (zeroize_s) begin
				blk1    <= '0;
				rng_out <= '0;
			end
		end
	end

	//------------------------------------------------------------
	// Key record CRC check
	//------------------------------------------------------------
	logic [sts_pkg::CRC_W-1:0] crc_calc;
	always_comb begin
		crc_calc = sts_pkg::CRC_INIT;
		for (int i = sts_pkg::REC_W - 1; i >= 0; i--) begin
			crc_calc = {crc_calc[sts_pkg::CRC_W-2:0], 1'b0}
				^ ((crc_calc[sts_pkg::CRC_W-1] ^ rec_fields[i]) ? sts_pkg::CRC_POLY
				: 16'h0000);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rec_corrupt <= 1'b0;
			rec_crc_new <= '0;
		end else if (rec_valid) begin
			rec_corrupt <= (crc_calc != rec_crc);
			rec_crc_new <= crc_calc;
		end
	end

	//------------------------------------------------------------
	// Sessions and password policy
	//------------------------------------------------------------
	wire pw_ok = pw_printable && (pw_len >= sts_pkg::PW_MIN) && (pw_len <= sts_pkg::PW_MAX);
	wire login_take = login_req && pw_ok && !session_active && in_ready;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			session_active <= 1'b0;
			login_ok       <= 1'b0;
		end else begin
			login_ok <= login_take;
			if (login_take) begin
				session_active <= 1'b1;
			end else if (logout_req || in_err) begin
				session_active <= 1'b0;
			end
		end
	end

	//------------------------------------------------------------
	// Gating and status outputs
	//------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			indicators   <= '0;
			status_pass  <= 1'b0;
			status_error <= 1'b0;
			busy         <= 1'b0;
		end else begin
			indicators   <= (next_state == sts_pkg::STS_IND_ON) ? sts_pkg::IND_ALL : '0;
			status_pass  <= (next_state == sts_pkg::STS_READY);
			status_error <= (next_state == sts_pkg::STS_ERR_HARD)
				|| (next_state == sts_pkg::STS_LOAD_ONLY);
			busy         <= keyload_busy;
		end
	end

	assign zeroize_now   = zeroize_s;
	assign key_read_en   = 1'b0;
	assign ready         = in_ready;
	assign crypto_en     = in_ready & ~busy & ~zeroize_s;
	assign svc_grant     = svc_req & crypto_en & session_active;
	assign data_out_en   = in_ready & ~testing & ~busy & ~zeroize_s;
	assign load_accept   = (state == sts_pkg::STS_LOAD_ONLY) & load_done & load_sig_ok;
endmodule

// ---- sim/sts_supervisor_asserts.sv ----
// Purpose: Concurrent checks on the self-test supervisor ports
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound to every sts_supervisor instance
module sts_supervisor_asserts (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        key_read_en,
	input wire logic        status_error,
	input wire logic        status_pass,
	input wire logic        crypto_en,
	input wire logic        data_out_en,
	input wire logic        ready,
	input wire logic [1:0]  indicators,
	input wire logic        rng_valid,
	input wire logic [31:0] rng_data,
	input wire logic        rng_out_valid,
	input wire logic [31:0] rng_out,
	input wire logic        login_ok,
	input wire logic [5:0]  pw_len,
	input wire logic        pw_printable,
	input wire logic        session_active,
	input wire logic        keyload_busy,
	input wire logic        svc_grant,
	input wire logic        zeroize_now
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ----------------
	// Checks
	// ----------------
	AST_KEY_HIDDEN: assert property (key_read_en == 1'b0)
		else $error("key read path open");
	AST_ERR_GATES: assert property (status_error |-> !crypto_en && !data_out_en && !ready)
		else $error("service open in error state");
	AST_ERR_HOLDS: assert property ($rose(status_error) |=> status_error [*8])
		else $error("error state left without power cycle");
	AST_STATUS_EXCL: assert property (!(status_pass && status_error))
		else $error("pass and error shown together");
	AST_IND_FIRST: assert property ($fell(sys_rst) |=> indicators == sts_pkg::IND_ALL)
		else $error("indicators not driven active after power-up");
	AST_RNG_ECHO: assert property (rng_out_valid |-> $past(rng_valid)
		&& rng_out == $past(rng_data))
		else $error("generator output differs from request");
	AST_NO_DATA_UNREADY: assert property (!ready |-> !data_out_en)
		else $error("data output open while not ready");
	AST_PW_RANGE: assert property (login_ok |-> $past(pw_printable)
		&& $past(pw_len) inside {[sts_pkg::PW_MIN:sts_pkg::PW_MAX]})
		else $error("login granted with bad password");
	AST_ONE_SESSION: assert property (login_ok |-> !$past(session_active))
		else $error("second session admitted");
	AST_KEYLOAD_HOLD: assert property (keyload_busy |=> !svc_grant)
		else $error("service granted during key loading");
	AST_ZERO_GATE: assert property (zeroize_now |-> !data_out_en && !crypto_en)
		else $error("output open during zeroize");
	COV_READY: cover property ($rose(ready));
	COV_ERROR: cover property ($rose(status_error));
	COV_LOGIN: cover property (login_ok);
	COV_RNG: cover property (rng_out_valid);
endmodule

bind sts_supervisor sts_supervisor_asserts i_sts_supervisor_asserts (.*);

// ---- sim/sts_engine_model.sv ----
// Purpose: Behavioural self-test engines answering the supervisor
// Assumes: Answer delay set by the bench, 1 to 8 cycles (delay 0 to 7)
// Notes:   fail_step picks the step that reports a bad result
module sts_engine_model #(
	parameter logic [31:0] REF_BLK = 32'hA5A5_5A5A
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                eng_start,
	input  wire sts_pkg::sts_state_t eng_step,
	input  wire sts_pkg::sts_state_t fail_step,
	input  wire logic [3:0]          delay,
	output logic                     eng_done,
	output logic                     eng_match,
	output logic [31:0]              eng_block
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic       busy;
	logic       g1;
	assign busy = eng_start && eng_step != sts_pkg::STS_IND_ON && eng_step != sts_pkg::STS_IND_OFF;
	assign g1 = fail_step == sts_pkg::STS_GEN1;
	assign eng_match = eng_done ? (eng_step != fail_step || g1) : cnt[0];
	// ----------------
	// Blocks per step
	// ----------------
	always_comb begin
		eng_block = {8{cnt}};
		if (eng_done && eng_step == sts_pkg::STS_GEN1)
			eng_block = g1 ? 32'h0000_0001 : 32'h0000_FFFF;
		if (eng_done && eng_step == sts_pkg::STS_GEN2)
			eng_block = g1 ? 32'h0000_0002 : (eng_match ? 32'h00FF_FF00 : 32'h0000_FFFF);
		if (eng_done && eng_step == sts_pkg::STS_REF)
			eng_block = REF_BLK;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt      <= 4'h0;
			eng_done <= 1'b0;
		end else begin
			eng_done <= busy && !eng_done && cnt == delay;
			cnt      <= (busy && !eng_done && cnt != delay) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// ---- sim/tb_sts_supervisor.sv ----
// Purpose: Self-checking bench for the self-test supervisor
// Assumes: Engines come from sts_engine_model
// Notes:   Each power cycle is a reset pulse
module tb_sts_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] REF_BLK = 32'hA5A5_5A5A;
	logic clk = 0, sys_rst = 1, test_req_pin = 0, eng_done, eng_match, rng_valid = 0, eng_start;
	logic load_done = 0, load_sig_ok = 0, rec_valid = 0, zeroize_pin = 0, login_req = 0;
	logic logout_req = 0, pw_printable = 1, keyload_busy = 0, svc_req = 1, login_ok;
	logic rng_out_valid, load_accept, rec_corrupt, zeroize_now, key_read_en, svc_grant;
	logic session_active, crypto_en, data_out_en, ready, status_pass, status_error, e;
	logic [31:0] eng_block, rng_data = 0, rng_out;
	logic [63:0] rec_fields = 0, f;
	logic [15:0] rec_crc = 0, rec_crc_new;
	logic [5:0]  pw_len = 0;
	logic [3:0]  delay = 0;
	logic [1:0]  indicators;
	sts_pkg::sts_state_t eng_step, fail_step = sts_pkg::STS_READY;
	sts_pkg::sts_state_t fl [4] = '{sts_pkg::STS_ENC, sts_pkg::STS_DEC, sts_pkg::STS_GEN1,
		sts_pkg::STS_GEN2};
	int fail_count = 0, check_count = 0;

	sts_supervisor i_sts_supervisor (.*);
	sts_engine_model #(.REF_BLK(REF_BLK)) i_sts_engine_model (.*);
	always #5 clk = ~clk;
	// ----------------
	// Helpers
	// ----------------
	function automatic logic [15:0] crc16(input logic [63:0] d);
		logic [15:0] c;
		c = sts_pkg::CRC_INIT;
		for (int b = 63; b >= 0; b--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? sts_pkg::CRC_POLY : 16'h0000);
		return c;
	endfunction
	function automatic logic pw_ok(input logic [5:0] len, input logic pr);
		return pr && len >= sts_pkg::PW_MIN && len <= sts_pkg::PW_MAX;
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic wait_ready;
		int n;
		for (n = 0; n < 800 && ready !== 1'b1 && status_error !== 1'b1; n++)
			@(posedge clk);
		#1;
		if (n == 800) begin
			fail_count++;
			report_and_stop;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic power(input sts_pkg::sts_state_t fs);
		@(posedge clk);
		fail_step <= fs;
		delay <= 4'($urandom_range(0, 7));
		sys_rst <= 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		tick(2);
		chk(indicators, sts_pkg::IND_ALL);
		tick(105);
		chk(indicators, 2'h0);
		wait_ready;
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		void'($urandom(32'hd94c));
		power(sts_pkg::STS_READY);
		chk({ready, status_pass, status_error, crypto_en, data_out_en, key_read_en}, 6'h36);
		for (int k = 0; k < 20; k++) begin
			@(posedge clk);
			rng_valid <= 1'b1;
			rng_data <= (k == 0) ? 32'hFFFF_FFFF : $urandom;
			@(posedge clk);
			rng_valid <= 1'b0;
			#1 chk({rng_out_valid, rng_out}, {1'b1, rng_data});
		end
		for (int k = 0; k < 4; k++) begin
			f = {$urandom, $urandom};
			@(posedge clk);
			rec_valid <= 1'b1;
			rec_fields <= f;
			rec_crc <= crc16(f) ^ 16'(k % 2);
			@(posedge clk);
			rec_valid <= 1'b0;
			#1 chk({rec_corrupt, rec_crc_new}, {k[0], crc16(f)});
		end
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			login_req <= 1'b1;
			pw_len <= 6'(k == 4 ? 20 : 14 + k + (k > 1 ? 14 : 0));
			pw_printable <= k != 4;
			e = pw_ok(6'(k == 4 ? 20 : 14 + k + (k > 1 ? 14 : 0)), k != 4);
			@(posedge clk);
			login_req <= 1'b0;
			#1 chk(login_ok, e);
			@(posedge clk);
			login_req <= 1'b1;
			pw_len <= 6'h14;
			pw_printable <= 1'b1;
			@(posedge clk);
			login_req <= 1'b0;
			#1 chk({login_ok, session_active}, {!e, 1'b1});
			@(posedge clk);
			logout_req <= k != 4;
			@(posedge clk);
			logout_req <= 1'b0;
		end
		keyload_busy <= 1'b1;
		tick(2);
		chk(svc_grant, 1'b0);
		@(posedge clk);
		keyload_busy <= 1'b0;
		tick(2);
		chk(svc_grant, 1'b1);
		@(posedge clk);
		zeroize_pin <= 1'b1;
		tick(3);
		chk({zeroize_now, data_out_en}, 2'h2);
		@(posedge clk);
		zeroize_pin <= 1'b0;
		test_req_pin <= 1'b1;
		tick(5);
		chk({ready, data_out_en}, 2'h0);
		wait_ready;
		chk({ready, status_error}, 2'h2);
		@(posedge clk);
		test_req_pin <= 1'b0;
		rng_valid <= 1'b1;
		rng_data <= REF_BLK;
		@(posedge clk);
		rng_valid <= 1'b0;
		#1 chk(rng_out_valid, 1'b0);
		tick(3);
		chk({status_error, crypto_en, data_out_en, ready}, 4'h8);
		for (int k = 0; k < 4; k++) begin
			power(fl[k]);
			chk({ready, status_pass, status_error, crypto_en}, 4'h2);
		end
		for (int j = 1; j >= 0; j--) begin
			power(sts_pkg::STS_SIG);
			chk({status_error, crypto_en, ready}, 3'h4);
			@(posedge clk);
			load_done <= 1'b1;
			load_sig_ok <= j[0];
			#1 chk(load_accept, j[0]);
			@(posedge clk);
			load_done <= 1'b0;
		end
		tick(3);
		chk({status_error, crypto_en, ready}, 3'h4);
		report_and_stop;
	end
endmodule
